/* logic/pws_pkg.sv */
// shared constants for the programming word parameter store
package pws_pkg;
   localparam logic [7:0]  PWS_PORT_ADDR   = 8'hC8;
   localparam int          PWS_WORD_W      = 16;
   localparam int          PWS_FIRST_BIT   = 15;
   localparam logic [2:0]  PWS_SEL_BLK0    = 3'h4;
   localparam logic [2:0]  PWS_SEL_BLK1    = 3'h5;
   localparam logic [2:0]  PWS_SEL_BLK2    = 3'h6;
   localparam logic [2:0]  PWS_SEL_RSVD    = 3'h7;
   localparam int          PWS_PAY12_W     = 12;
   localparam int          PWS_PAY14_W     = 14;
   localparam int          PWS_BLK0_WORDS  = 8;
   localparam int          PWS_BLK1_WORDS  = 6;
   localparam int          PWS_BLK2_WORDS  = 5;
   localparam int          PWS_BLK4_WORDS  = 9;
   localparam logic [15:0] PWS_FSYNC_RST   = 16'hCB23;
   localparam logic [15:0] PWS_BSYNC_RST   = 16'h5555;
   localparam logic [10:0] PWS_LEVEL_MAX   = 11'h600;
   localparam int          PWS_ABSORB_US   = 250;
   localparam int          PWS_CLK_MHZ     = 100;
   localparam int          PWS_ABSORB_CYC  = PWS_ABSORB_US * PWS_CLK_MHZ;
   localparam int          PWS_TONE_MS_40  = 40;
   localparam int          PWS_TONE_MS_60  = 60;
   localparam int          PWS_TONE_MS_80  = 80;
   localparam int          PWS_TONE_MS_100 = 100;
   localparam logic [13:0] PWS_LIMIT_FULL  = 14'h3FFF;
   // apb register map of the controller end
   localparam logic [7:0]  PWS_CTL_DATA    = 8'h00;
   localparam logic [7:0]  PWS_CTL_STATUS  = 8'h04;
   typedef enum logic [1:0] {
      PWS_HS_IDLE, PWS_HS_SEND, PWS_HS_WAIT
   } pws_hs_t;
endpackage : pws_pkg

/* logic/pws_if.sv */
// programming word port between the host controller and the store
`timescale 1ns/10ps
interface pws_if;
   logic [15:0] word;
   logic        write;
   logic        ready;
   modport store (input word, input write, output ready);
   modport host  (output word, output write, input ready);
endinterface : pws_if

/* logic/pws_store.sv */
// device end: parameter store behind the programming word port
//
// Overview of operation
// - header bits pick block and first word
// - ready drops on write, returns when absorbed
// - host writes words in order per block
// - frame sync from two bytes, resets CB23
// - scramble seed built from two bytes
// - zero seed means no scrambling
// - bit sync pattern resets to 5555
// - tone level from payload bits 11..1
// - bit 0 gates receive de-emphasis
// - tone length code gives 40..100 ms
// - transmit tone lasts programmed length
// - silent prefix/suffix at least tone length
// - accept 1.5x length, reject over 2x
// - detect threshold field bits 9..4
// - four-bit bandwidth code selects window
// - tone word integer part in bits 10..4
// - remainder part rounded from formula
// - host keeps tones 400 to 3000 Hz
// - host never writes reserved block 3
// - long code select picks 24/23 bits
`timescale 1ns/10ps
module pws_store
   import pws_pkg::*;
#(
   parameter int ABSORB_CYC = PWS_ABSORB_CYC
) (
   // clock and reset
   input  wire logic        I_CLOCK,
   input  wire logic        I_NRST,
   // programming port
   pws_if.store             PORT,
   // context from other control registers
   input  wire logic        I_PD_BIT4,
   input  wire logic        I_VOICE_EMPH_EN,
   // stored parameters
   output logic [15:0]      O_FRAME_SYNC,
   output logic [15:0]      O_SEED1,
   output logic [15:0]      O_SEED2,
   output logic             O_SEED1_BYPASS,
   output logic             O_SEED2_BYPASS,
   output logic [15:0]      O_BIT_SYNC,
   output logic [10:0]      O_TONE_LEVEL,
   output logic             O_RX_DEEMPH,
   output logic [6:0]       O_TONE_MS,
   output logic [5:0]       O_DETECT_THR,
   output logic [3:0]       O_BANDWIDTH,
   output logic [6:0]       O_TONE_N [4],
   output logic [3:0]       O_TONE_R [4],
   output logic [11:0]      O_SUB_LEVEL,
   output logic             O_LONG_CODE_SELECT,
   output logic [23:0]      O_SQ_CODE,
   output logic [3:0]       O_DROPOUT,
   output logic [13:0]      O_GAIN [8],
   output logic             O_LIMIT_FULL,
   output logic             O_BAD_WORD
);
   logic [15:0] w;
   logic [2:0]  sel;
   logic        first;
   logic [3:0]  next_idx;
   logic [11:0] p12;
   logic [13:0] p14;
   logic [31:0] busy_cnt;
   logic        busy;
   logic        ready;
   logic [15:0] seed1;
   logic [15:0] seed2;
   logic [3:0]  cur_idx;
   logic [1:0]  tlen;
   logic        emph_bit;

   assign w     = PORT.word;
   assign first = w[PWS_FIRST_BIT];
   assign sel   = w[14] ? w[14:12] : 3'h0;
   assign p12   = w[PWS_PAY12_W-1:0];
   assign p14   = w[PWS_PAY14_W-1:0];
   // first word restarts the block count, otherwise continue
   assign next_idx = first ? 4'h0 : cur_idx;

   // ready flag: cleared by write, set after absorption time
   always_ff @(posedge I_CLOCK) begin
      if (!I_NRST) begin
         ready    <= 1'b1;
         busy_cnt <= 32'h0;
      end else if (PORT.write) begin
         ready    <= 1'b0;
         busy_cnt <= 32'h0;
      end else if (busy) begin
         busy_cnt <= busy_cnt + 32'h1;
         if (busy_cnt >= 32'(ABSORB_CYC - 1)) begin
            ready <= 1'b1;
         end
      end
   end
   // the port sees the flop itself, no gate in between
   assign busy       = !ready;
   assign PORT.ready = ready;

   // block tracking; a stray write while busy is flagged
   always_ff @(posedge I_CLOCK) begin
      if (!I_NRST) begin
         cur_idx    <= 4'h0;
         O_BAD_WORD <= 1'b0;
      end else if (PORT.write) begin
         cur_idx    <= next_idx + 4'h1;
         O_BAD_WORD <= busy || (sel == PWS_SEL_RSVD);
      end
   end

   // block 0: modem configuration
   always_ff @(posedge I_CLOCK) begin
      if (!I_NRST) begin
         O_FRAME_SYNC <= PWS_FSYNC_RST;
         seed1        <= 16'h0000;
         seed2        <= 16'h0000;
         O_BIT_SYNC   <= PWS_BSYNC_RST;
      end else if (!I_PD_BIT4 && O_BIT_SYNC == 16'h0000) begin
         O_BIT_SYNC   <= PWS_BSYNC_RST;
      end else if (PORT.write && !busy && sel == PWS_SEL_BLK0) begin
         case (next_idx)
            4'h0: O_FRAME_SYNC[7:0]  <= p12[7:0];
            4'h1: O_FRAME_SYNC[15:8] <= p12[7:0];
            4'h2: seed1[7:0]         <= p12[7:0];
            4'h3: seed1[15:8]        <= p12[7:0];
            4'h4: seed2[7:0]         <= p12[7:0];
            4'h5: seed2[15:8]        <= p12[7:0];
            4'h6: O_BIT_SYNC[7:0]    <= p12[7:0];
            4'h7: O_BIT_SYNC[15:8]   <= p12[7:0];
            default: ;
         endcase
      end
   end
   always_ff @(posedge I_CLOCK) begin
      if (!I_NRST) begin
         O_SEED1        <= 16'h0000;
         O_SEED2        <= 16'h0000;
         O_SEED1_BYPASS <= 1'b1;
         O_SEED2_BYPASS <= 1'b1;
      end else begin
         O_SEED1        <= seed1;
         O_SEED2        <= seed2;
         O_SEED1_BYPASS <= (seed1 == 16'h0000);
         O_SEED2_BYPASS <= (seed2 == 16'h0000);
      end
   end

   // block 1: tone levels, timing, detection and tone words
   always_ff @(posedge I_CLOCK) begin
      if (!I_NRST) begin
         O_TONE_LEVEL <= 11'h000;
         emph_bit     <= 1'b0;
         tlen         <= 2'h0;
         O_DETECT_THR <= 6'h00;
         O_BANDWIDTH  <= 4'h8;
         for (int k = 0; k < 4; k++) begin
            O_TONE_N[k] <= 7'h00;
            O_TONE_R[k] <= 4'h0;
         end
      end else if (PORT.write && !busy && sel == PWS_SEL_BLK1) begin
         case (next_idx)
            4'h0: begin
               // clip so an out-of-range value cannot overdrive
               O_TONE_LEVEL <= (p12[11:1] > PWS_LEVEL_MAX) ?
                               PWS_LEVEL_MAX : p12[11:1];
               emph_bit     <= p12[0];
            end
            4'h1: begin
               tlen         <= p12[11:10];
               O_DETECT_THR <= p12[9:4];
               O_BANDWIDTH  <= p12[3:0];
            end
            4'h2, 4'h3, 4'h4, 4'h5: begin
               O_TONE_N[2'(next_idx - 4'h2)] <= p12[10:4];
               O_TONE_R[2'(next_idx - 4'h2)] <= p12[3:0];
            end
            default: ;
         endcase
      end
   end
   always_ff @(posedge I_CLOCK) begin
      if (!I_NRST) begin
         O_RX_DEEMPH <= 1'b0;
         O_TONE_MS   <= 7'(PWS_TONE_MS_40);
      end else begin
         O_RX_DEEMPH <= emph_bit && I_VOICE_EMPH_EN;
         // this length drives tx tone time, rx gaps and windows
         case (tlen)
            2'h0:    O_TONE_MS <= 7'(PWS_TONE_MS_40);
            2'h1:    O_TONE_MS <= 7'(PWS_TONE_MS_60);
            2'h2:    O_TONE_MS <= 7'(PWS_TONE_MS_80);
            default: O_TONE_MS <= 7'(PWS_TONE_MS_100);
         endcase
      end
   end

   // block 2: sub-audio setup
   always_ff @(posedge I_CLOCK) begin
      if (!I_NRST) begin
         O_SUB_LEVEL        <= 12'h000;
         O_LONG_CODE_SELECT <= 1'b0;
         O_SQ_CODE          <= 24'h000000;
         O_DROPOUT          <= 4'h0;
      end else if (PORT.write && !busy && sel == PWS_SEL_BLK2) begin
         case (next_idx)
            4'h0: O_SUB_LEVEL        <= p12;
            4'h1: O_LONG_CODE_SELECT <= p12[11];
            4'h2: O_SQ_CODE[11:0]    <= p12;
            4'h3: O_SQ_CODE[23:12]   <= p12;
            4'h4: O_DROPOUT          <= p12[11:8];
            default: ;
         endcase
      end
   end

   // block 4: gains and offsets, production word ignored
   always_ff @(posedge I_CLOCK) begin
      if (!I_NRST) begin
         for (int k = 0; k < 8; k++) begin
            O_GAIN[k] <= 14'h0000;
         end
         O_LIMIT_FULL <= 1'b0;
      end else if (PORT.write && !busy && sel == 3'h0) begin
         if (next_idx < 4'h8) begin
            O_GAIN[3'(next_idx)] <= p14;
         end
         if (next_idx == 4'h7) begin
            O_LIMIT_FULL <= (p14 == PWS_LIMIT_FULL);
         end
      end
   end
endmodule : pws_store

/* logic/pws_host.sv */
// host end: apb controlled writer for the programming word port
`timescale 1ns/10ps
module pws_host
   import pws_pkg::*;
(
   // clock and reset
   input  wire logic        I_CLOCK,
   input  wire logic        I_NRST,
   // apb slave
   input  wire logic        I_PSEL,
   input  wire logic        I_PENABLE,
   input  wire logic        I_PWRITE,
   input  wire logic [7:0]  I_PADDR,
   input  wire logic [31:0] I_PWDATA,
   output logic [31:0]      O_PRDATA,
   output logic             O_PREADY,
   output logic             O_PSLVERR,
   // programming port
   pws_if.host              PORT
);
   pws_hs_t     state;
   logic [15:0] word;
   logic        wr;
   logic        acc;
   logic [2:0]  sel;

   assign acc = I_PSEL && I_PENABLE && O_PREADY;
   assign sel = I_PWDATA[14] ? I_PWDATA[14:12] : 3'h0;

   // ready one cycle after setup; unmapped gives an error
   always_ff @(posedge I_CLOCK) begin
      if (!I_NRST) begin
         O_PREADY  <= 1'b0;
         O_PSLVERR <= 1'b0;
         O_PRDATA  <= 32'h0;
      end else begin
         O_PREADY  <= I_PSEL && !I_PENABLE;
         O_PSLVERR <= I_PSEL && !I_PENABLE &&
                      I_PADDR != PWS_CTL_DATA && I_PADDR != PWS_CTL_STATUS;
         O_PRDATA  <= (I_PSEL && !I_PWRITE && I_PADDR == PWS_CTL_STATUS)
                      ? {30'h0, state != PWS_HS_IDLE, PORT.ready} : 32'h0;
      end
   end

   // only pass a word while idle and the store is ready
   always_ff @(posedge I_CLOCK) begin
      if (!I_NRST) begin
         state <= PWS_HS_IDLE;
         word  <= 16'h0000;
         wr    <= 1'b0;
      end else begin
         wr <= 1'b0;
         case (state)
            PWS_HS_IDLE:
               if (acc && I_PWRITE && I_PADDR == PWS_CTL_DATA &&
                   sel != PWS_SEL_RSVD) begin
                  word  <= I_PWDATA[15:0];
                  state <= PWS_HS_SEND;
               end
            PWS_HS_SEND:
               if (PORT.ready) begin
                  wr    <= 1'b1;
                  state <= PWS_HS_WAIT;
               end
            PWS_HS_WAIT:
               if (!wr && PORT.ready) begin
                  state <= PWS_HS_IDLE;
               end
            default: state <= PWS_HS_IDLE;
         endcase
      end
   end
   assign PORT.word  = word;
   assign PORT.write = wr;
endmodule : pws_host

/* testbench/pws_assertions.sv */
// protocol checks on the programming word link between the two ends
`timescale 1ns/10ps
module pws_assertions
   import pws_pkg::*;
#(
   parameter int ABSORB_CYC = PWS_ABSORB_CYC
) (
   // clock and reset
   input  wire logic        I_CLOCK,
   input  wire logic        I_NRST,
   // programming word link
   input  wire logic [15:0] i_word,
   input  wire logic        i_write,
   input  wire logic        i_ready
);
   int unsigned low_cnt;
   default clocking @(posedge I_CLOCK); endclocking
   default disable iff (!I_NRST);
   // length of the current busy stretch, cleared while ready
   always_ff @(posedge I_CLOCK) begin
      if (!I_NRST || i_ready)
         low_cnt <= 0;
      else
         low_cnt <= low_cnt + 1;
   end
   accept_drop_a: assert property (i_write |=> !i_ready)
      else $error("ready stayed high after a word");
   write_ready_a: assert property (i_write |-> i_ready)
      else $error("word written while store busy");
   write_pulse_a: assert property (i_write |=> !i_write)
      else $error("write strobe longer than one cycle");
   busy_hold_a: assert property
      ($fell(i_ready) |-> !i_ready [*8])
      else $error("ready returned too early");
   absorb_min_a: assert property
      ($rose(i_ready) |-> low_cnt >= ABSORB_CYC - 1)
      else $error("absorb time too short");
   absorb_max_a: assert property
      (!i_ready |-> low_cnt <= ABSORB_CYC + 1)
      else $error("absorb time too long");
   silent_drop_a: assert property
      ($fell(i_ready) |-> $past(i_write))
      else $error("ready fell without a word");
   word_hold_a: assert property (!i_ready |=> $stable(i_word))
      else $error("word changed while store busy");
   no_rsvd_a: assert property
      (i_write |-> i_word[14:12] != PWS_SEL_RSVD)
      else $error("word sent to reserved block");
   cover property (i_write && i_word[15]);
   cover property (i_write && !i_word[14]);
   cover property ($rose(i_ready));
endmodule : pws_assertions

/* testbench/tb_prog_word_param_store.sv */
// self-checking bench: apb host end driving the parameter store
`timescale 1ns/10ps
`define CHK(a, e) begin n_checks++; if ((a) !== (e)) begin n_fail++; \
   $display("mismatch t=%0t got %h exp %h", $time, (a), (e)); end end
module tb_prog_word_param_store
   import pws_pkg::*;
;
   localparam int ABS = 20;
   logic        clk, nrst, psel, penable, pwrite, prdy, perr, err, pd4, een;
   logic        b1, b2, deemph, lcs, lim, bad;
   logic [7:0]  paddr, v [8];
   logic [31:0] pwdata, prdata, rd;
   logic [15:0] frame, s1, s2, bs;
   logic [10:0] lvl, lv, tw;
   logic [6:0]  tms, tn [4];
   logic [5:0]  thr, th;
   logic [3:0]  bw, tr [4], drop;
   logic [11:0] sub, sl;
   logic [23:0] sq, q;
   logic [13:0] gain [8], g [8];
   logic        e;
   int          n_fail = 0, n_checks = 0, cyc = 0, seed = 67516, f;
   pws_if link ();
   pws_host pws_host_i (.I_CLOCK(clk), .I_NRST(nrst), .I_PSEL(psel),
      .I_PENABLE(penable), .I_PWRITE(pwrite), .I_PADDR(paddr),
      .I_PWDATA(pwdata), .O_PRDATA(prdata), .O_PREADY(prdy),
      .O_PSLVERR(perr), .PORT(link));
   pws_store #(.ABSORB_CYC(ABS)) pws_store_i (.I_CLOCK(clk), .I_NRST(nrst),
      .PORT(link), .I_PD_BIT4(pd4), .I_VOICE_EMPH_EN(een),
      .O_FRAME_SYNC(frame), .O_SEED1(s1), .O_SEED2(s2),
      .O_SEED1_BYPASS(b1), .O_SEED2_BYPASS(b2), .O_BIT_SYNC(bs),
      .O_TONE_LEVEL(lvl), .O_RX_DEEMPH(deemph), .O_TONE_MS(tms),
      .O_DETECT_THR(thr), .O_BANDWIDTH(bw), .O_TONE_N(tn), .O_TONE_R(tr),
      .O_SUB_LEVEL(sub), .O_LONG_CODE_SELECT(lcs), .O_SQ_CODE(sq),
      .O_DROPOUT(drop), .O_GAIN(gain), .O_LIMIT_FULL(lim), .O_BAD_WORD(bad));
   pws_assertions #(.ABSORB_CYC(ABS)) pws_assertions_i (.I_CLOCK(clk),
      .I_NRST(nrst), .i_word(link.word), .i_write(link.write),
      .i_ready(link.ready));
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         n_fail++;
         results();
      end
   end
   task automatic results();
      $display("checks %0d mismatches %0d", n_checks, n_fail);
      if (n_fail == 0 && n_checks > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask : results
   // one apb transfer; request held until pready is sampled high
   task automatic apb(input logic w, input logic [7:0] a,
                      input logic [31:0] d);
      @(posedge clk);
      psel    <= 1'b1;
      pwrite  <= w;
      paddr   <= a;
      pwdata  <= d;
      @(posedge clk);
      penable <= 1'b1;
      do @(posedge clk); while (prdy !== 1'b1);
      rd = prdata;
      err = perr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask : apb
   // poll until the store is ready and the host end is idle
   task automatic idle();
      do apb(1'b0, PWS_CTL_STATUS, 32'h0); while (rd[1:0] !== 2'b01);
   endtask : idle
   task automatic put(input logic [15:0] w);
      idle();
      apb(1'b1, PWS_CTL_DATA, {16'h0, w});
   endtask : put
   // integer part in the upper bits, rounded remainder below
   function automatic logic [10:0] tone(input int fr);
      real x;
      int  n;
      x = 0.042666 * fr;
      n = int'($floor(x));
      return {7'(n), 4'(int'((x - n) * 6000.0 / fr))};
   endfunction : tone
   // hold reset for n cycles, then check the reset values
   task automatic reset_run(input int n);
      nrst <= 1'b0;
      repeat (n) @(posedge clk);
      nrst <= 1'b1;
      @(posedge clk);
      `CHK(frame, PWS_FSYNC_RST)
      `CHK(bs, PWS_BSYNC_RST)
      `CHK(b1, 1'b1)
      `CHK(tms, 7'h28)
      `CHK(bw, 4'h8)
   endtask : reset_run
   initial begin
      psel    = 1'b0;
      penable = 1'b0;
      pwrite  = 1'b0;
      paddr   = 8'h00;
      pwdata  = 32'h0;
      pd4     = 1'b0;
      een     = 1'b1;
      reset_run(16);
      apb(1'b0, 8'h40, 32'h0);
      `CHK(err, 1'b1)
      for (int k = 0; k < 3; k++) begin
         for (int j = 0; j < 8; j++)
            v[j] = (k == 0 && j < 4 && j > 1) ? 8'h00 : 8'($random(seed));
         // round 2: zero bit sync, kept only while pd bit 4 is set
         pd4 <= (k == 2);
         v[6][0] = 1'b1;
         if (k == 2) begin
            v[6] = 8'h00;
            v[7] = 8'h00;
         end
         for (int j = 0; j < 8; j++)
            put({j == 0, PWS_SEL_BLK0, 4'h0, v[j]});
         idle();
         `CHK(frame, {v[1], v[0]})
         `CHK(s1, {v[3], v[2]})
         `CHK(s2, {v[5], v[4]})
         `CHK(b1, ({v[3], v[2]} == 16'h0))
         `CHK(b2, ({v[5], v[4]} == 16'h0))
         `CHK(bs, {v[7], v[6]})
         if (k == 2) begin
            pd4 <= 1'b0;
            repeat (2) @(posedge clk);
            `CHK(bs, PWS_BSYNC_RST)
         end
         $display("block 0 round %0d done", k);
      end
      for (int k = 0; k < 4; k++) begin
         lv = (k == 3) ? PWS_LEVEL_MAX : 11'($unsigned($random(seed)) % 1537);
         e = 1'($random(seed));
         th = 6'($random(seed));
         f = (k == 0) ? 1010 : 400 + $unsigned($random(seed)) % 2577;
         tw = tone(f);
         een <= k[0];
         put({1'b1, PWS_SEL_BLK1, lv, e});
         put({1'b0, PWS_SEL_BLK1, 2'(k), th, 2'b10, 2'(k)});
         for (int i = 0; i < 4; i++)
            put({1'b0, PWS_SEL_BLK1, 1'b0, tw});
         idle();
         `CHK(lvl, lv)
         `CHK(deemph, e & k[0])
         `CHK(tms, 7'(40 + 20 * k))
         `CHK(thr, th)
         `CHK(bw, {2'b10, 2'(k)})
         for (int i = 0; i < 4; i++) begin
            `CHK(tn[i], tw[10:4])
            `CHK(tr[i], tw[3:0])
         end
         $display("block 1 round %0d done", k);
      end
      for (int k = 0; k < 2; k++) begin
         sl = 12'($random(seed));
         put({1'b1, PWS_SEL_BLK2, sl});
         put({1'b0, PWS_SEL_BLK2, k[0], 1'b0, th, 4'h8});
         q = 24'($random(seed));
         put({1'b0, PWS_SEL_BLK2, q[11:0]});
         put({1'b0, PWS_SEL_BLK2, q[23:12]});
         put({1'b0, PWS_SEL_BLK2, q[3:0], 8'h00});
         idle();
         `CHK(sub, sl)
         `CHK(lcs, k[0])
         `CHK(sq, q)
         `CHK(drop, q[3:0])
         $display("block 2 round %0d done", k);
      end
      // a reserved-block word must be refused by the host end
      put({1'b1, PWS_SEL_RSVD, 12'hABC});
      apb(1'b0, PWS_CTL_STATUS, 32'h0);
      `CHK(rd[1:0], 2'b01)
      `CHK(bad, 1'b0)
      $display("reserved block test done");
      for (int k = 0; k < 2; k++) begin
         for (int i = 0; i < 8; i++)
            g[i] = (k == 0 && i == 7) ? PWS_LIMIT_FULL : 14'($random(seed));
         for (int i = 0; i < 8; i++)
            put({i == 0, 1'b0, g[i]});
         idle();
         for (int i = 0; i < 8; i++)
            `CHK(gain[i], g[i])
         `CHK(lim, (g[7] == PWS_LIMIT_FULL))
         `CHK(bad, 1'b0)
         $display("block 4 round %0d done", k);
      end
      reset_run(2);
      $display("mid-run reset test done");
      results();
   end
endmodule : tb_prog_word_param_store
